// *** logic/mac_error_stats.sv ***
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module mac_error_stats (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // AHB-Lite register port
    input wire logic HSEL_I,
    input wire logic [mac_stat_pkg::ADDR_W-1:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic HREADY_I,
    input wire logic [mac_stat_pkg::DATA_W-1:0] HWDATA_I,
    output logic [mac_stat_pkg::DATA_W-1:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Configuration
    input wire logic [mac_stat_pkg::DATA_W-1:0] NET_CONFIG_I,
    input wire logic FULL_DUPLEX_I,
    input wire logic SPEED_100_I,
    // Transmit frame report
    input wire logic TX_DONE_I,
    input wire logic TX_CRS_SEEN_I,
    input wire logic TX_CRS_LOST_I,
    input wire logic TX_COL_I,
    input wire logic TX_UNDERRUN_I,
    // Receive frame report
    input wire logic RX_DONE_I,
    input wire logic [mac_stat_pkg::LEN_W-1:0] RX_LEN_I,
    input wire logic [15:0] RX_LEN_FIELD_I,
    input wire logic RX_CRC_ERR_I,
    input wire logic RX_NONINTEGRAL_I,
    input wire logic RX_ADDR_MATCH_I,
    input wire logic RX_NO_BUFFER_I,
    input wire logic RX_OVERRUN_I,
    // Media-independent interface
    input wire logic MII_RX_DV_I,
    input wire logic MII_RX_ER_I,
    input wire logic MII_TX_EN_I,
    input wire logic MII_COL_I,
    // Error strobes and interrupt
    output logic FCS_ERR_O,
    output logic ALIGN_ERR_O,
    output logic IRQ_O
);
    import mac_stat_pkg::*;

    typedef struct packed {
        logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
        logic [NUM_CNT-1:0] status;
        logic [NUM_CNT-1:0] irq_mask;
        logic irq;
        logic rx_er_seen;
        logic fcs_err;
        logic align_err;
    } core_s;

    core_s st_reg;
    core_s st_next;
    stat_reg_if regs();
    logic sqe_fail;
    logic [NUM_CNT-1:0] inc;
    logic [NUM_CNT-1:0] wr_sel;
    logic sym_err;
    logic bad;
    logic too_long;
    logic in_range;
    logic len_mis;
    logic carrier_err;
    logic [LEN_W-1:0] max_len;
    logic [LEN_W-1:0] payload;

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic up,
                                              input logic [IDX_W-1:0] idx);
        return (v + {{(CNT_W-1){1'b0}}, up}) & cnt_mask(idx);
    endfunction : bump

    function automatic logic [DATA_W-1:0] read_word(input core_s s,
                                                    input logic [IDX_W-1:0] idx);
        if (idx < IDX_W'(NUM_CNT)) begin
            return {{(DATA_W-CNT_W){1'b0}}, s.cnt[idx] & cnt_mask(idx)};
        end
        if (idx == STATUS_IDX) begin
            return {{(DATA_W-NUM_CNT){1'b0}}, s.status};
        end
        if (idx == MASK_IDX) begin
            return {{(DATA_W-NUM_CNT){1'b0}}, s.irq_mask};
        end
        return '0;
    endfunction : read_word

    stat_ahb_slave u_ahb (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hready_i(HREADY_I),
        .hwdata_i(HWDATA_I),
        .hrdata_o(HRDATA_O),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O),
        .regs(regs.bus)
    );

    sqe_watch u_sqe (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .half_duplex_i(~FULL_DUPLEX_I),
        .speed_100_i(SPEED_100_I),
        .tx_en_i(MII_TX_EN_I),
        .col_i(MII_COL_I),
        .fail_o(sqe_fail)
    );

    assign regs.rdata = read_word(st_reg, regs.ridx);

    assign max_len = NET_CONFIG_I[NCFG_BIG_BIT] ? MAX_BIG_FRAME_LEN : MAX_FRAME_LEN;
    // rx_er anywhere in the frame, the last cycle included
    assign sym_err = st_reg.rx_er_seen | (MII_RX_DV_I & MII_RX_ER_I);
    assign bad = RX_CRC_ERR_I | sym_err;
    assign too_long = RX_LEN_I > max_len;
    assign in_range = (RX_LEN_I >= MIN_FRAME_LEN) && !too_long;
    // Data bytes are the frame less header and FCS
    assign payload = (RX_LEN_I > HDR_FCS_BYTES) ? RX_LEN_I - HDR_FCS_BYTES : '0;
    // measured data shorter than length field
    // type IDs and overlong frames excluded
    assign len_mis = NET_CONFIG_I[NCFG_LCHK_BIT] && (RX_LEN_FIELD_I < TYPE_ID_MIN)
        && !too_long && ({{(16-LEN_W){1'b0}}, payload} < RX_LEN_FIELD_I);
    // carrier missing or lost, no collision, no underrun
    assign carrier_err = TX_DONE_I && !FULL_DUPLEX_I && (!TX_CRS_SEEN_I || TX_CRS_LOST_I)
        && !TX_COL_I && !TX_UNDERRUN_I;

    always_comb begin
        inc = '0;
        // carrier error drives only its own counter
        inc[CARRIER_IDX] = carrier_err;
        inc[NOBUF_IDX] = RX_DONE_I & RX_ADDR_MATCH_I & RX_NO_BUFFER_I;
        inc[OVERRUN_IDX] = RX_DONE_I & RX_ADDR_MATCH_I & RX_OVERRUN_I;
        inc[SYMBOL_IDX] = RX_DONE_I & sym_err;
        inc[TOOLONG_IDX] = RX_DONE_I & too_long & !bad;
        inc[JABBER_IDX] = RX_DONE_I & too_long & bad;
        inc[SHORT_IDX] = RX_DONE_I & (RX_LEN_I < MIN_FRAME_LEN) & !bad;
        inc[SQE_IDX] = sqe_fail;
        inc[LENMIS_IDX] = RX_DONE_I & len_mis;
    end

    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < NUM_CNT; i++) begin
            wr_sel[i] = regs.wr && (regs.widx == IDX_W'(i));
            // write loads the count, a same-cycle event still adds
            st_next.cnt[i] = bump(wr_sel[i] ? regs.wdata[CNT_W-1:0] : st_reg.cnt[i],
                                  inc[i], IDX_W'(i));
        end
        // Read clears, but an event in the same cycle survives
        if (regs.rd && regs.ridx == STATUS_IDX) begin
            st_next.status = '0;
        end
        st_next.status = st_next.status | inc;
        if (regs.wr && regs.widx == MASK_IDX) begin
            st_next.irq_mask = regs.wdata[NUM_CNT-1:0];
        end
        st_next.irq = |(st_next.status & st_next.irq_mask);
        if (RX_DONE_I) begin
            st_next.rx_er_seen = 1'b0;
        end else if (MII_RX_DV_I && MII_RX_ER_I) begin
            st_next.rx_er_seen = 1'b1;
        end
        // CRC or symbol error in a valid-length frame
        st_next.fcs_err = RX_DONE_I && in_range && !RX_NONINTEGRAL_I
            && (RX_CRC_ERR_I || sym_err);
        st_next.align_err = RX_DONE_I && in_range && RX_NONINTEGRAL_I
            && (RX_CRC_ERR_I || sym_err);
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign FCS_ERR_O = st_reg.fcs_err;
    assign ALIGN_ERR_O = st_reg.align_err;
    assign IRQ_O = st_reg.irq;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    AST_CARRIER_INC: assert property (
        (TX_DONE_I && !FULL_DUPLEX_I && !TX_CRS_SEEN_I && !TX_COL_I && !TX_UNDERRUN_I
         && !wr_sel[CARRIER_IDX]) |=> st_reg.cnt[CARRIER_IDX]
         == bump($past(st_reg.cnt[CARRIER_IDX]), 1'b1, CARRIER_IDX))
        else $error("carrier error not counted");

    AST_CARRIER_FULL: assert property (
        (FULL_DUPLEX_I && !sqe_fail && !wr_sel[CARRIER_IDX]) |=> $stable(st_reg.cnt[CARRIER_IDX]))
        else $error("carrier counter moved in full duplex");

    AST_CARRIER_ALONE: assert property (
        (carrier_err && !RX_DONE_I && !sqe_fail && !regs.wr) |=> $stable(st_reg.cnt[NUM_CNT-1:1]))
        else $error("carrier error changed another counter");

    AST_NOBUF_INC: assert property (
        (RX_DONE_I && RX_ADDR_MATCH_I && RX_NO_BUFFER_I && !wr_sel[NOBUF_IDX])
        |=> st_reg.cnt[NOBUF_IDX] == bump($past(st_reg.cnt[NOBUF_IDX]), 1'b1, NOBUF_IDX))
        else $error("no-buffer drop not counted");

    AST_SYM_FCS: assert property (
        (RX_DONE_I && sym_err && in_range && !RX_NONINTEGRAL_I) |=> FCS_ERR_O && !ALIGN_ERR_O)
        else $error("symbol error not flagged as FCS error");

    AST_SYM_JABBER: assert property (
        (RX_DONE_I && sym_err && too_long && !wr_sel[JABBER_IDX]) |=> st_reg.cnt[JABBER_IDX]
        == bump($past(st_reg.cnt[JABBER_IDX]), 1'b1, JABBER_IDX))
        else $error("overlong symbol error not counted as jabber");

    AST_BIG_LIMIT: assert property (
        (RX_DONE_I && NET_CONFIG_I[NCFG_BIG_BIT] && RX_LEN_I == MAX_BIG_FRAME_LEN
         && !wr_sel[TOOLONG_IDX] && !wr_sel[JABBER_IDX])
        |=> $stable(st_reg.cnt[TOOLONG_IDX]) && $stable(st_reg.cnt[JABBER_IDX]))
        else $error("1536-byte frame treated as overlong");

    AST_SHORT_INC: assert property (
        (RX_DONE_I && RX_LEN_I < MIN_FRAME_LEN && !bad && !wr_sel[SHORT_IDX])
        |=> st_reg.cnt[SHORT_IDX] == bump($past(st_reg.cnt[SHORT_IDX]), 1'b1, SHORT_IDX))
        else $error("short frame not counted");

    AST_LEN_OFF: assert property (
        (!NET_CONFIG_I[NCFG_LCHK_BIT] && !wr_sel[LENMIS_IDX]) |=> $stable(st_reg.cnt[LENMIS_IDX]))
        else $error("length mismatch counted with check off");

    AST_TYPE_ID: assert property (
        (RX_LEN_FIELD_I >= TYPE_ID_MIN && !wr_sel[LENMIS_IDX]) |=> $stable(st_reg.cnt[LENMIS_IDX]))
        else $error("type ID frame counted as length mismatch");

    AST_UPPER_ZERO: assert property (
        regs.rd && regs.ridx == CARRIER_IDX |-> regs.rdata[DATA_W-1:8] == '0)
        else $error("upper bits of 8-bit counter not zero");

    AST_IRQ_LEVEL: assert property (
        (|(inc & st_reg.irq_mask) && !(regs.wr && regs.widx == MASK_IDX)) |=> IRQ_O)
        else $error("unmasked event did not raise irq");

    AST_MASK_LOAD: assert property (
        (regs.wr && regs.widx == MASK_IDX) |=> st_reg.irq_mask == $past(regs.wdata[NUM_CNT-1:0]))
        else $error("irq mask not loaded");

    AST_STATUS_SET: assert property (
        (inc != '0) |=> (st_reg.status & $past(inc)) == $past(inc))
        else $error("event did not set status");

    AST_STATUS_CLEAR: assert property (
        (regs.rd && regs.ridx == STATUS_IDX && inc == '0) |=> st_reg.status == '0)
        else $error("status read did not clear");

    AST_OVERRUN_INC: assert property (
        (RX_DONE_I && RX_ADDR_MATCH_I && RX_OVERRUN_I && !wr_sel[OVERRUN_IDX])
        |=> st_reg.cnt[OVERRUN_IDX] == bump($past(st_reg.cnt[OVERRUN_IDX]), 1'b1, OVERRUN_IDX))
        else $error("overrun not counted");

    AST_RXER_LATCH: assert property (
        (MII_RX_DV_I && MII_RX_ER_I && !RX_DONE_I) |=> st_reg.rx_er_seen)
        else $error("symbol error not held");

    AST_SYMBOL_INC: assert property (
        (RX_DONE_I && st_reg.rx_er_seen && !wr_sel[SYMBOL_IDX])
        |=> st_reg.cnt[SYMBOL_IDX] == bump($past(st_reg.cnt[SYMBOL_IDX]), 1'b1, SYMBOL_IDX))
        else $error("symbol error frame not counted");

    AST_ALIGN: assert property (
        (RX_DONE_I && (RX_CRC_ERR_I || st_reg.rx_er_seen) && RX_NONINTEGRAL_I
         && RX_LEN_I >= MIN_FRAME_LEN && RX_LEN_I <= max_len) |=> ALIGN_ERR_O && !FCS_ERR_O)
        else $error("alignment error not flagged");

    AST_LONG_NO_STROBE: assert property (
        (RX_DONE_I && RX_LEN_I > max_len) |=> !FCS_ERR_O && !ALIGN_ERR_O)
        else $error("overlong frame flagged as FCS error");

    AST_TOOLONG_INC: assert property (
        (RX_DONE_I && RX_LEN_I > max_len && !RX_CRC_ERR_I && !sym_err && !wr_sel[TOOLONG_IDX])
        |=> st_reg.cnt[TOOLONG_IDX] == bump($past(st_reg.cnt[TOOLONG_IDX]), 1'b1, TOOLONG_IDX))
        else $error("clean overlong frame not counted");

    AST_JABBER_INC: assert property (
        (RX_DONE_I && RX_LEN_I > max_len && RX_CRC_ERR_I && !wr_sel[JABBER_IDX])
        |=> st_reg.cnt[JABBER_IDX] == bump($past(st_reg.cnt[JABBER_IDX]), 1'b1, JABBER_IDX))
        else $error("jabber not counted");

    AST_SQE_INC: assert property (
        (sqe_fail && !wr_sel[SQE_IDX])
        |=> st_reg.cnt[SQE_IDX] == bump($past(st_reg.cnt[SQE_IDX]), 1'b1, SQE_IDX))
        else $error("SQE failure not counted");

    AST_SQE_IDLE: assert property (
        (!sqe_fail && !wr_sel[SQE_IDX]) |=> $stable(st_reg.cnt[SQE_IDX]))
        else $error("SQE counter moved alone");

    AST_LEN_MIS_INC: assert property (
        (RX_DONE_I && len_mis && !wr_sel[LENMIS_IDX])
        |=> st_reg.cnt[LENMIS_IDX] == bump($past(st_reg.cnt[LENMIS_IDX]), 1'b1, LENMIS_IDX))
        else $error("length mismatch not counted");

    AST_WRITE_LOAD: assert property (
        (wr_sel[JABBER_IDX] && !inc[JABBER_IDX])
        |=> st_reg.cnt[JABBER_IDX] == ($past(regs.wdata[CNT_W-1:0]) & MASK_8))
        else $error("counter write not loaded");

    COV_CARRIER: cover property (carrier_err ##1 IRQ_O);
    COV_JABBER: cover property (RX_DONE_I && too_long && bad);
    COV_SQE: cover property (sqe_fail);
    COV_READ_CLEAR: cover property (regs.rd && regs.ridx == STATUS_IDX && |inc);
endmodule : mac_error_stats

// *** logic/mac_stat_pkg.sv ***
package mac_stat_pkg;
    // Bus and register file geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 4;
    localparam int IDX_LSB = 2;
    localparam int NUM_CNT = 9;
    localparam int CNT_W = 16;
    localparam int LEN_W = 14;

    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] CARRIER_IDX = 4'h0;
    localparam logic [IDX_W-1:0] NOBUF_IDX = 4'h1;
    localparam logic [IDX_W-1:0] OVERRUN_IDX = 4'h2;
    localparam logic [IDX_W-1:0] SYMBOL_IDX = 4'h3;
    localparam logic [IDX_W-1:0] TOOLONG_IDX = 4'h4;
    localparam logic [IDX_W-1:0] JABBER_IDX = 4'h5;
    localparam logic [IDX_W-1:0] SHORT_IDX = 4'h6;
    localparam logic [IDX_W-1:0] SQE_IDX = 4'h7;
    localparam logic [IDX_W-1:0] LENMIS_IDX = 4'h8;
    localparam logic [IDX_W-1:0] STATUS_IDX = 4'h9;
    localparam logic [IDX_W-1:0] MASK_IDX = 4'ha;
    localparam logic [IDX_W-1:0] LAST_IDX = MASK_IDX;

    // Counter widths as read masks
    localparam logic [CNT_W-1:0] MASK_8 = 16'h00ff;
    localparam logic [CNT_W-1:0] MASK_16 = 16'hffff;

    // Frame length limits in bytes
    localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 14'h0040;
    localparam logic [LEN_W-1:0] MAX_FRAME_LEN = 14'h05ee;
    localparam logic [LEN_W-1:0] MAX_BIG_FRAME_LEN = 14'h0600;
    localparam logic [LEN_W-1:0] HDR_FCS_BYTES = 14'h0012;
    localparam logic [15:0] TYPE_ID_MIN = 16'h0600;

    // Network configuration bits
    localparam int NCFG_BIG_BIT = 8;
    localparam int NCFG_LCHK_BIT = 16;

    // SQE window timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_NS_10M = 100;
    localparam int BIT_NS_100M = 10;
    localparam int DIV_10M = BIT_NS_10M / CLK_PERIOD_NS;
    localparam int DIV_100M = BIT_NS_100M / CLK_PERIOD_NS;
    localparam int SQE_GAP_BITS = 96;
    localparam int DIV_W = 7;
    localparam int BITCNT_W = 7;

    // AHB-Lite codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    function automatic logic [CNT_W-1:0] cnt_mask(input logic [IDX_W-1:0] idx);
        return (idx == NOBUF_IDX) ? MASK_16 : MASK_8;
    endfunction : cnt_mask
endpackage : mac_stat_pkg

// *** logic/stat_reg_if.sv ***
`timescale 1ns/1ps
interface stat_reg_if;
    import mac_stat_pkg::*;
    logic rd;
    logic [IDX_W-1:0] ridx;
    logic wr;
    logic [IDX_W-1:0] widx;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport bus (output rd, ridx, wr, widx, wdata, input rdata);
    modport core (input rd, ridx, wr, widx, wdata, output rdata);
endinterface : stat_reg_if

// *** logic/stat_ahb_slave.sv ***
`timescale 1ns/1ps
module stat_ahb_slave (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite
    input wire logic hsel_i,
    input wire logic [mac_stat_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [mac_stat_pkg::DATA_W-1:0] hwdata_i,
    output logic [mac_stat_pkg::DATA_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Register side
    stat_reg_if.bus regs
);
    import mac_stat_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [IDX_W-1:0] widx;
        logic [DATA_W-1:0] hrdata;
        logic ready;
    } ahb_s;

    ahb_s st_reg;
    ahb_s st_next;
    logic accept;
    logic hit;
    logic [IDX_W-1:0] aidx;

    assign accept = hsel_i & hready_i & htrans_i[1];
    assign aidx = haddr_i[IDX_LSB +: IDX_W];
    // Unmapped or sub-word accesses read zero and write nothing
    assign hit = (haddr_i[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (aidx <= LAST_IDX)
        && (hsize_i == HSIZE_WORD) && (haddr_i[IDX_LSB-1:0] == '0);
    assign regs.rd = accept & ~hwrite_i & hit;
    assign regs.ridx = aidx;
    assign regs.wr = st_reg.wr_pend;
    assign regs.widx = st_reg.widx;
    assign regs.wdata = hwdata_i;

    always_comb begin
        st_next = st_reg;
        st_next.ready = 1'b1;
        st_next.wr_pend = accept & hwrite_i & hit;
        if (accept) begin
            st_next.widx = aidx;
        end
        if (accept && !hwrite_i) begin
            st_next.hrdata = hit ? regs.rdata : '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata_o = st_reg.hrdata;
    assign hreadyout_o = st_reg.ready;
    assign hresp_o = HRESP_OKAY;
endmodule : stat_ahb_slave

// *** logic/sqe_watch.sv ***
`timescale 1ns/1ps
module sqe_watch (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link state
    input wire logic half_duplex_i,
    input wire logic speed_100_i,
    input wire logic tx_en_i,
    input wire logic col_i,
    // Result
    output logic fail_o
);
    import mac_stat_pkg::*;

    typedef struct packed {
        logic tx_en_d;
        logic armed;
        logic [DIV_W-1:0] div;
        logic [BITCNT_W-1:0] bits;
        logic fail;
    } sqe_s;

    localparam logic [BITCNT_W-1:0] GAP_LAST = BITCNT_W'(SQE_GAP_BITS - 1);

    sqe_s st_reg;
    sqe_s st_next;
    logic [DIV_W-1:0] div_last;

    assign div_last = speed_100_i ? DIV_W'(DIV_100M - 1) : DIV_W'(DIV_10M - 1);

    always_comb begin
        st_next = st_reg;
        st_next.fail = 1'b0;
        st_next.tx_en_d = tx_en_i;
        if (st_reg.tx_en_d && !tx_en_i && half_duplex_i) begin
            st_next.armed = 1'b1;
            st_next.div = '0;
            st_next.bits = '0;
        end else if (st_reg.armed) begin
            // A new frame or a duplex change ends the watch without a verdict
            if (col_i || tx_en_i || !half_duplex_i) begin
                st_next.armed = 1'b0;
            end else if (st_reg.div == div_last) begin
                st_next.div = '0;
                if (st_reg.bits == GAP_LAST) begin
                    st_next.armed = 1'b0;
                    st_next.fail = 1'b1;
                end else begin
                    st_next.bits = st_reg.bits + 1'b1;
                end
            end else begin
                st_next.div = st_reg.div + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fail_o = st_reg.fail;

    AST_SQE_COL_OK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_reg.armed && col_i) |=> !fail_o)
        else $error("SQE failure despite collision");
endmodule : sqe_watch

// *** testbench/mii_phy_model.sv ***
`timescale 1ns/1ps
module mii_phy_model #(
    parameter int COL_DELAY = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench control
    input wire logic sqe_on_i,
    input wire logic rx_go_i,
    input wire logic rx_bad_i,
    // Media-independent interface
    input wire logic tx_en_i,
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic col_o
);
    logic [4:0] rx_cnt;
    logic [4:0] sqe_cnt;
    logic tx_d;

    // Heartbeat answer starts only on a falling tx_en, like a real transceiver
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_cnt <= 5'h0;
            sqe_cnt <= 5'h0;
            tx_d <= 1'b0;
        end else begin
            tx_d <= tx_en_i;
            rx_cnt <= rx_go_i ? 5'h8 : rx_cnt - 5'(rx_cnt != 5'h0);
            if (tx_d && !tx_en_i && sqe_on_i) begin
                sqe_cnt <= 5'(COL_DELAY);
            end else if (sqe_cnt != 5'h0) begin
                sqe_cnt <= sqe_cnt - 5'h1;
            end
        end
    end

    // Error symbol only inside the burst, so the latch sees it with data valid
    assign rx_dv_o = rx_cnt != 5'h0;
    assign rx_er_o = rx_bad_i && rx_cnt == 5'h4;
    assign col_o = sqe_cnt inside {[5'h1:5'h3]};
endmodule : mii_phy_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import mac_stat_pkg::*;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, tx_en = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0, hrdata, ncfg = 0, d;
    logic fdx = 1, spd = 1, tx_done = 0, crs_seen = 0, crs_lost = 0, tx_col = 0, tx_und = 0;
    logic rx_done = 0, crc = 0, nonint = 0, amatch = 0, nobuf = 0, ovr = 0;
    logic [13:0] rx_len = 0;
    logic [15:0] rx_fld = 0;
    logic rx_dv, rx_er, col, fcs, aln, irq, sqe_on = 0, rx_go = 0, rx_bad = 0;
    logic [31:0] ex [9] = '{32'h2, 32'h2346, 32'h1, 32'h3, 32'h2, 32'h25, 32'h2, 32'h0, 32'h0};
    int bad_count = 0, total_checks = 0, cyc = 0, fcs_n = 0, aln_n = 0;

    mac_error_stats dut (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hready),
        .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .NET_CONFIG_I(ncfg), .FULL_DUPLEX_I(fdx), .SPEED_100_I(spd), .TX_DONE_I(tx_done),
        .TX_CRS_SEEN_I(crs_seen), .TX_CRS_LOST_I(crs_lost), .TX_COL_I(tx_col),
        .TX_UNDERRUN_I(tx_und), .RX_DONE_I(rx_done), .RX_LEN_I(rx_len), .RX_LEN_FIELD_I(rx_fld),
        .RX_CRC_ERR_I(crc), .RX_NONINTEGRAL_I(nonint), .RX_ADDR_MATCH_I(amatch),
        .RX_NO_BUFFER_I(nobuf), .RX_OVERRUN_I(ovr), .MII_RX_DV_I(rx_dv), .MII_RX_ER_I(rx_er),
        .MII_TX_EN_I(tx_en), .MII_COL_I(col), .FCS_ERR_O(fcs), .ALIGN_ERR_O(aln), .IRQ_O(irq));
    mii_phy_model phy (.clk_i(clk), .rst_n_i(rst_n), .sqe_on_i(sqe_on), .rx_go_i(rx_go),
        .rx_bad_i(rx_bad), .tx_en_i(tx_en), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .col_o(col));

    initial begin
        forever #5 clk = ~clk;
    end

    // Strobes last one cycle, so they are tallied on every edge
    always @(posedge clk) begin
        cyc++;
        fcs_n += int'(fcs === 1'b1);
        aln_n += int'(aln === 1'b1);
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Called just after a rising edge; waits on hready with no fixed latency
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, a, w, HSIZE_WORD};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        {htrans, hwdata} <= {2'b00, wd};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb

    task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        ahb(1'b0, a, 32'h0, d);
        chk(n, e, d);
    endtask : rdc

    task rxf(input logic [13:0] len, input logic [15:0] fld, input logic [3:0] f);
        {rx_len, rx_fld, nobuf, ovr, crc, nonint, amatch, rx_done} <= {len, fld, f, 2'b11};
        @(posedge clk);
        rx_done <= 1'b0;
        @(posedge clk);
    endtask : rxf

    task symerr;
        {rx_go, rx_bad} <= 2'b11;
        @(posedge clk);
        rx_go <= 1'b0;
        repeat (10) @(posedge clk);
        rx_bad <= 1'b0;
    endtask : symerr

    task txf(input logic [3:0] f);
        {crs_seen, crs_lost, tx_col, tx_und, tx_done} <= {f, 1'b1};
        @(posedge clk);
        tx_done <= 1'b0;
        @(posedge clk);
    endtask : txf

    task txen(input logic s);
        {sqe_on, tx_en} <= {s, 1'b1};
        repeat (5) @(posedge clk);
        tx_en <= 1'b0;
        repeat (110) @(posedge clk);
    endtask : txen

    task irqc(input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge clk);
    endtask : irqc

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 9; i++) rdc(8'(4 * i), 32'h0, "reset_count");
        rdc(8'h2c, 32'h0, "unmapped");
        chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
        ahb(1'b1, 8'h04, 32'hfff12345, d);
        rdc(8'h04, 32'h2345, "no_buffer_write");
        ahb(1'b1, 8'h14, 32'h123, d);
        rdc(8'h14, 32'h23, "jabber_write");
        ahb(1'b0, 8'h24, 32'h0, d);
        $display("test registers done");
        fdx <= 1'b0;
        txf(4'b0000);
        txf(4'b1100);
        txf(4'b1000);
        txf(4'b0010);
        txf(4'b0001);
        rdc(8'h00, 32'h2, "carrier_half");
        fdx <= 1'b1;
        txf(4'b0000);
        rdc(8'h00, 32'h2, "carrier_full");
        rdc(8'h24, 32'h1, "status_carrier");
        $display("test carrier done");
        rxf(14'd40, 16'h0, 4'h0);
        rxf(14'd100, 16'h0, 4'h8);
        rxf(14'd100, 16'h0, 4'h4);
        symerr();
        rxf(14'd100, 16'h0, 4'h0);
        rxf(14'd100, 16'h0, 4'h3);
        rxf(14'd1519, 16'h0, 4'h0);
        rxf(14'd1518, 16'h0, 4'h0);
        ncfg <= 32'h100;
        rxf(14'd1536, 16'h0, 4'h2);
        rxf(14'd1537, 16'h0, 4'h0);
        rxf(14'd1537, 16'h0, 4'h2);
        symerr();
        rxf(14'd1600, 16'h0, 4'h0);
        symerr();
        rxf(14'd40, 16'h0, 4'h0);
        rxf(14'd63, 16'h0, 4'h0);
        rxf(14'd64, 16'h0, 4'h0);
        for (int i = 0; i < 9; i++) rdc(8'(4 * i), ex[i], $sformatf("count_%0d", i));
        chk("fcs_pulses", 32'h2, 32'(fcs_n));
        chk("align_pulses", 32'h1, 32'(aln_n));
        $display("test receive done");
        ncfg <= 32'h10000;
        rxf(14'd64, 16'd100, 4'h0);
        rxf(14'd64, 16'd46, 4'h0);
        rxf(14'd64, 16'h0600, 4'h0);
        rxf(14'd1520, 16'h05ff, 4'h0);
        ncfg <= 32'h0;
        rxf(14'd64, 16'd100, 4'h0);
        rdc(8'h20, 32'h1, "length_mismatch");
        rdc(8'h10, 32'h3, "too_long");
        $display("test length done");
        ahb(1'b0, 8'h24, 32'h0, d);
        ahb(1'b1, 8'h28, 32'h40, d);
        rdc(8'h28, 32'h40, "irq_mask");
        rxf(14'd100, 16'h0, 4'h4);
        irqc(1'b0);
        rxf(14'd40, 16'h0, 4'h0);
        irqc(1'b1);
        rdc(8'h24, 32'h44, "status_irq");
        irqc(1'b0);
        $display("test interrupt done");
        fdx <= 1'b0;
        txen(1'b0);
        txen(1'b1);
        rdc(8'h1c, 32'h1, "sqe_half");
        fdx <= 1'b1;
        txen(1'b0);
        rdc(8'h1c, 32'h1, "sqe_full");
        {fdx, spd} <= 2'b00;
        txen(1'b0);
        rdc(8'h1c, 32'h1, "sqe_10m_early");
        repeat (860) @(posedge clk);
        rdc(8'h1c, 32'h2, "sqe_10m");
        $display("test sqe done");
        close_out();
    end
endmodule : tb_top
